// ---- include/ovs_pkg.sv ----
// package: constants and types of the overload and over-temperature supervisor
// Notes on behaviour
// - overload latch data is low; a reset pulse clears it only once detect is low.
// - clearing the overload latch releases the amplifier input clamp.
// - persistent overload keeps the latch set; repeated reset pulses never clear it until detect drops.
// - device gives inverted and re-inverted buffered forms of low-frequency gain select.
// - hv gain select is low only when the 100kHz range is selected, or the 1kHz range with kv low.
// - any of four temperature comparators tripped drives heatsink overheat high.
// - a missing overheat source reads as an over-temperature failure.
// - heatsink overheat is captured in a status register the processor reads.
// - limit detect high sets the latch and holds it; latch drives limit status low.
// - limit detect high asserts the input clamp at once; the set latch holds it.
package ovs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LIM_RST = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_OL_COUNT = 8'h18;

  // control register fields
  localparam int CTRL_LF_BIT = 0;
  localparam int CTRL_R0_BIT = 1;
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // interrupt bit positions
  localparam int IRQ_OL_SET = 0;
  localparam int IRQ_OL_CLR = 1;
  localparam int IRQ_HEAT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // synchroniser and counter figures
  localparam int SYNC_STAGES = 3;
  localparam int TEMP_CHANNELS = 4;
  localparam int OL_COUNT_W = 8;
  localparam logic [7:0] OL_COUNT_RESET = 8'h00;
  localparam logic [7:0] OL_COUNT_MAX = 8'hFF;

  // status register layout, high bits first
  typedef struct packed {
    logic [OL_COUNT_W-1:0] pulses_held;
    logic hv_gain;
    logic lf_gain;
    logic clamp;
    logic detect;
    logic latch;
    logic heat;
    logic limit_status_n;
  } ovs_status_t;

  localparam int STATUS_W = OL_COUNT_W + 7;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ovs_req_t;

  // decodes one register offset, used by the write path
  function automatic logic ovs_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

endpackage

// ---- rtl/ovs_sync.sv ----
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ovs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule // ovs_sync
`default_nettype wire

// ---- rtl/ovs_supervisor.sv ----
// module: overload latch, hv gain select and heatsink overheat supervisor
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ovs_supervisor #(
  parameter int TEMP_N = ovs_pkg::TEMP_CHANNELS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [ovs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ovs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ovs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic limit_detect,
  input wire logic [TEMP_N-1:0] temp_trip,
  input wire logic pa_present,
  output logic limit_status_n,
  output logic limit_reset_pulse,
  output logic amp_input_clamp,
  output logic low_freq_gain_select_n,
  output logic low_freq_gain_select,
  output logic hv_gain_select,
  output logic heatsink_overheat,
  output logic irq
);

  ovs_pkg::ovs_req_t req;
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // pin inputs cross into mclk; pa_present is pulled to absent during reset
  logic [TEMP_N+1:0] pins_raw;
  logic [TEMP_N+1:0] pins_s;
  assign pins_raw = {pa_present, limit_detect, temp_trip};

  ovs_sync #(
    .WIDTH(TEMP_N + 2)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic det_s;
  logic present_s;
  logic [TEMP_N-1:0] trip_s;
  assign trip_s = pins_s[TEMP_N-1:0];
  assign det_s = pins_s[TEMP_N];
  assign present_s = pins_s[TEMP_N+1];

  // write decode
  logic wr_ctrl;
  logic wr_lim_rst;
  logic wr_irq_en;
  logic wr_irq_clr;
  assign wr_ctrl = req.wr && ovs_pkg::ovs_hit(req.addr, ovs_pkg::OFS_CTRL);
  assign wr_lim_rst = req.wr && ovs_pkg::ovs_hit(req.addr, ovs_pkg::OFS_LIM_RST);
  assign wr_irq_en = req.wr && ovs_pkg::ovs_hit(req.addr, ovs_pkg::OFS_IRQ_EN);
  assign wr_irq_clr = req.wr && ovs_pkg::ovs_hit(req.addr, ovs_pkg::OFS_IRQ_CLR);

  // control register and link-driven reset pulse
  logic [ovs_pkg::CTRL_W-1:0] ctrl_q;
  logic [ovs_pkg::CTRL_W-1:0] ctrl_d;
  logic rst_pulse_q;
  logic rst_pulse_d;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = reg_wdata[ovs_pkg::CTRL_W-1:0];
    end
    // any write to the reset register is one limit-reset clock pulse
    rst_pulse_d = wr_lim_rst;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl_q <= ovs_pkg::CTRL_RESET;
      rst_pulse_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rst_pulse_q <= rst_pulse_d;
    end
  end

  // overload latch
  logic latch_q;
  logic latch_d;
  logic [ovs_pkg::OL_COUNT_W-1:0] held_q;
  logic [ovs_pkg::OL_COUNT_W-1:0] held_d;

  always_comb begin
    latch_d = latch_q;
    if (det_s) begin
      // set dominates, so a pulse during detect never clears it
      latch_d = 1'b1;
    end else if (rst_pulse_q) begin
      latch_d = 1'b0;
    end
    // counts pulses refused because detect was still high
    held_d = held_q;
    if (rst_pulse_q && det_s && held_q != ovs_pkg::OL_COUNT_MAX) begin
      held_d = held_q + 1'b1;
    end else if (!latch_q) begin
      held_d = ovs_pkg::OL_COUNT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      latch_q <= 1'b0;
      held_q <= ovs_pkg::OL_COUNT_RESET;
    end else begin
      latch_q <= latch_d;
      held_q <= held_d;
    end
  end

  // overload event count, saturating, readable
  logic [ovs_pkg::OL_COUNT_W-1:0] ol_cnt_q;
  logic [ovs_pkg::OL_COUNT_W-1:0] ol_cnt_d;
  logic ol_set_ev;
  logic ol_clr_ev;
  assign ol_set_ev = latch_d && !latch_q;
  assign ol_clr_ev = !latch_d && latch_q;

  always_comb begin
    ol_cnt_d = ol_cnt_q;
    if (ol_set_ev && ol_cnt_q != ovs_pkg::OL_COUNT_MAX) begin
      ol_cnt_d = ol_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ol_cnt_q <= ovs_pkg::OL_COUNT_RESET;
    end else begin
      ol_cnt_q <= ol_cnt_d;
    end
  end

  // output flops
  logic clamp_q;
  logic clamp_d;
  logic lf_n_q;
  logic lf_n_d;
  logic lf_q;
  logic lf_d;
  logic hv_q;
  logic hv_d;
  logic heat_q;
  logic heat_d;

  always_comb begin
    // detect drives the clamp directly; the latch keeps it on after detect drops
    clamp_d = det_s || latch_d;
    lf_n_d = !ctrl_d[ovs_pkg::CTRL_LF_BIT];
    lf_d = !lf_n_d;
    // low only for lf=0, r0=1, which selects 100kHz, or 1kHz when kv is low
    hv_d = ctrl_d[ovs_pkg::CTRL_LF_BIT] || !ctrl_d[ovs_pkg::CTRL_R0_BIT];
    // a missing amplifier assembly must look like a failure, never as cool
    heat_d = (|trip_s) || !present_s;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clamp_q <= 1'b0;
      lf_n_q <= 1'b1;
      lf_q <= 1'b0;
      hv_q <= 1'b1;
      heat_q <= 1'b0;
    end else begin
      clamp_q <= clamp_d;
      lf_n_q <= lf_n_d;
      lf_q <= lf_d;
      hv_q <= hv_d;
      heat_q <= heat_d;
    end
  end

  // interrupts: sticky, set wins over a clear in the same cycle
  logic [ovs_pkg::IRQ_W-1:0] irq_stat_q;
  logic [ovs_pkg::IRQ_W-1:0] irq_stat_d;
  logic [ovs_pkg::IRQ_W-1:0] irq_en_q;
  logic [ovs_pkg::IRQ_W-1:0] irq_en_d;
  logic [ovs_pkg::IRQ_W-1:0] irq_set;
  logic [ovs_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[ovs_pkg::IRQ_OL_SET] = ol_set_ev;
    irq_set[ovs_pkg::IRQ_OL_CLR] = ol_clr_ev;
    irq_set[ovs_pkg::IRQ_HEAT] = heat_d && !heat_q;
    irq_clr = wr_irq_clr ? reg_wdata[ovs_pkg::IRQ_W-1:0] : '0;
    irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
    irq_en_d = wr_irq_en ? reg_wdata[ovs_pkg::IRQ_W-1:0] : irq_en_q;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_stat_q <= ovs_pkg::IRQ_RESET;
      irq_en_q <= ovs_pkg::IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
    end
  end

  // read path, data valid only in the cycle after the strobe
  ovs_pkg::ovs_status_t status;
  assign status.pulses_held = held_q;
  assign status.hv_gain = hv_q;
  assign status.lf_gain = lf_q;
  assign status.clamp = clamp_q;
  assign status.detect = det_s;
  assign status.latch = latch_q;
  assign status.heat = heat_q;
  assign status.limit_status_n = !latch_q;

  logic [ovs_pkg::DATA_W-1:0] rdata_q;
  logic [ovs_pkg::DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = '0;
    if (req.rd) begin
      case (req.addr)
        ovs_pkg::OFS_CTRL: rdata_d[ovs_pkg::CTRL_W-1:0] = ctrl_q;
        ovs_pkg::OFS_STATUS: rdata_d[ovs_pkg::STATUS_W-1:0] = status;
        ovs_pkg::OFS_IRQ_STAT: rdata_d[ovs_pkg::IRQ_W-1:0] = irq_stat_q;
        ovs_pkg::OFS_IRQ_EN: rdata_d[ovs_pkg::IRQ_W-1:0] = irq_en_q;
        ovs_pkg::OFS_OL_COUNT: rdata_d[ovs_pkg::OL_COUNT_W-1:0] = ol_cnt_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign limit_status_n = !latch_q;
  assign limit_reset_pulse = rst_pulse_q;
  assign amp_input_clamp = clamp_q;
  assign low_freq_gain_select_n = lf_n_q;
  assign low_freq_gain_select = lf_q;
  assign hv_gain_select = hv_q;
  assign heatsink_overheat = heat_q;
  assign irq = |(irq_stat_q & irq_en_q);

endmodule // ovs_supervisor
`default_nettype wire

// ---- dv/ovs_checker.sv ----
// checker: port assertions of the supervisor
`timescale 1ns/1ps
`default_nettype none
module ovs_checker #(
  parameter int TEMP_N = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic limit_detect,
  input wire logic [TEMP_N-1:0] temp_trip,
  input wire logic pa_present,
  input wire logic limit_status_n,
  input wire logic limit_reset_pulse,
  input wire logic amp_input_clamp,
  input wire logic low_freq_gain_select_n,
  input wire logic low_freq_gain_select,
  input wire logic hv_gain_select,
  input wire logic heatsink_overheat
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // eight cycles leave room for the synchroniser and the latch flop
  AST_SET: assert property (limit_detect [*8] |-> !limit_status_n)
    else $error("latch not set");
  AST_CLAMP: assert property (amp_input_clamp == !limit_status_n)
    else $error("clamp differs from latch");
  AST_HOLD: assert property (limit_detect [*8] ##0 limit_reset_pulse |=> !limit_status_n)
    else $error("latch cleared under detect");
  AST_CLEAR: assert property ((!limit_detect) [*8] ##0 limit_reset_pulse
    |=> limit_status_n && !amp_input_clamp)
    else $error("latch not cleared");
  AST_LF_PAIR: assert property (low_freq_gain_select_n != low_freq_gain_select)
    else $error("lf forms agree");
  AST_GAIN: assert property (reg_wr && reg_addr == 8'h00
    |=> low_freq_gain_select == $past(reg_wdata[0])
    && hv_gain_select == ($past(reg_wdata[0]) || !$past(reg_wdata[1])))
    else $error("gain select wrong");
  AST_HOT: assert property ((|temp_trip || !pa_present) [*8] |-> heatsink_overheat)
    else $error("overheat missing");
  AST_COOL: assert property ((temp_trip == '0 && pa_present) [*8] |-> !heatsink_overheat)
    else $error("overheat false");
  AST_READ: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata[1:0] == $past({heatsink_overheat, limit_status_n}))
    else $error("status read wrong");
endmodule // ovs_checker
bind ovs_supervisor ovs_checker #(.TEMP_N(TEMP_N)) chk (.*);
`default_nettype wire

// ---- dv/ovs_host.sv ----
// host model: register bus master and overload retry loop
`timescale 1ns/1ps
`default_nettype none
module ovs_host #(
  parameter int RECOVER_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic retry_en,
  input wire logic limit_status_n,
  input wire logic heatsink_overheat,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic ol_msg,
  output logic heat_msg
);
  // tasks and the retry loop own separate signals, so each has a single driver
  logic [7:0] task_addr = 8'h00;
  logic [31:0] task_wdata = 32'h0;
  logic task_wr = 1'b0;
  logic task_rd = 1'b0;
  logic loop_wr = 1'b0;
  logic msg_q = 1'b0;
  logic heat_msg_q = 1'b0;
  logic heat_seen = 1'b0;
  int rec_left = 0;
  assign reg_addr = loop_wr ? 8'h08 : task_addr;
  assign reg_wdata = task_wdata;
  assign reg_wr = loop_wr || task_wr;
  assign reg_rd = task_rd;
  assign ol_msg = msg_q;
  assign heat_msg = heat_msg_q;
  // pulses never stop while retry is enabled and status is active, so a lasting overload just stays latched
  always @(posedge mclk) begin
    loop_wr <= retry_en && !limit_status_n;
    msg_q <= !limit_status_n;
  end
  // recovery time is scaled down from about a minute to keep the run short
  always @(posedge mclk) begin
    heat_seen <= heatsink_overheat;
    if (heat_msg_q) begin
      rec_left <= rec_left - 1;
      if (rec_left == 1) begin
        heat_msg_q <= 1'b0;
      end
    end else if (heatsink_overheat && !heat_seen) begin
      heat_msg_q <= 1'b1;
      rec_left <= RECOVER_CYCLES;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    task_addr <= a;
    task_wdata <= d;
    task_wr <= 1'b1;
    @(posedge mclk);
    task_wr <= 1'b0;
    task_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    task_addr <= a;
    task_rd <= 1'b1;
    @(posedge mclk);
    task_rd <= 1'b0;
  endtask
  // codes 0..4 stand for the 100Hz..1MHz ranges
  task automatic set_range(input logic kv, input int f);
    wr(8'h00, {30'h0, f == 1 || f == 3, kv && f < 2});
  endtask
endmodule // ovs_host
`default_nettype wire

// ---- dv/test_overload_heatsink_overheat_supervisor.sv ----
// testbench: overload latch, gain select and overheat scenarios
`timescale 1ns/1ps
`default_nettype none
module test_overload_heatsink_overheat_supervisor;
  logic mclk = 0;
  logic nrst = 0;
  logic det = 0;
  logic [3:0] trip = '0;
  logic pa = 1;
  logic retry = 0;
  logic [31:0] rdata, wdata;
  logic [7:0] addr;
  logic wr, rd, stat_n, pulse, clamp, lf_n, lf, hv, heat, irq, msg, hmsg;
  // host recovery length in cycles, standing in for about a minute
  localparam int REC = 20;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  ovs_supervisor dut (.mclk(mclk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .limit_detect(det), .temp_trip(trip),
    .pa_present(pa), .limit_status_n(stat_n), .limit_reset_pulse(pulse),
    .amp_input_clamp(clamp), .low_freq_gain_select_n(lf_n), .low_freq_gain_select(lf),
    .hv_gain_select(hv), .heatsink_overheat(heat), .irq(irq));
  ovs_host #(.RECOVER_CYCLES(REC)) host (.mclk(mclk), .retry_en(retry),
    .limit_status_n(stat_n), .heatsink_overheat(heat), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .ol_msg(msg), .heat_msg(hmsg));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic set_det(input logic v);
    @(posedge mclk);
    det <= v;
  endtask
  task automatic t_overload;
    set_det(1);
    settle(8);
    chk("status_n", 0, stat_n);
    chk("clamp", 1, clamp);
    host.wr(8'h08, 0);
    #1 chk("pulse", 1, pulse);
    settle(2);
    chk("status_n", 0, stat_n);
    chk("pulse", 0, pulse);
    set_det(0);
    settle(8);
    chk("clamp", 1, clamp);
    host.wr(8'h08, 0);
    settle(2);
    chk("status_n", 1, stat_n);
    chk("clamp", 0, clamp);
  endtask
  task automatic t_retry;
    retry <= 1'b1;
    set_det(1);
    settle(20);
    chk("msg", 1, msg);
    chk("status_n", 0, stat_n);
    set_det(0);
    settle(12);
    chk("msg", 0, msg);
    chk("clamp", 0, clamp);
    retry <= 1'b0;
  endtask
  task automatic t_gain;
    for (int k = 0; k < 2; k++)
      for (int f = 0; f < (k ? 4 : 5); f++) begin
        host.set_range(k[0], f);
        settle(2);
        chk("lf", k == 1 && f < 2, lf);
        chk("lf_n", !(k == 1 && f < 2), lf_n);
        chk("hv", k == 1 ? f != 3 : !(f == 1 || f == 3), hv);
      end
  endtask
  task automatic irq_is(input logic e);
    settle(1);
    chk("irq", e, irq);
  endtask
  task automatic t_heat;
    host.wr(8'h10, 32'h4);
    host.wr(8'h14, 32'h7);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      trip <= 4'h1 << i;
      settle(8);
      chk("heat", 1, heat);
      host.rd(8'h04);
      #1 chk("status", 1, rdata[1]);
      irq_is(1);
      host.wr(8'h14, 32'h4);
      irq_is(0);
      @(posedge mclk);
      trip <= '0;
      settle(8);
      chk("heat", 0, heat);
    end
    host.wr(8'h10, 32'h0);
    pa <= 1'b0;
    settle(8);
    chk("heat", 1, heat);
    chk("heat_msg", 1, hmsg);
    irq_is(0);
    host.wr(8'h10, 32'h4);
    irq_is(1);
    host.wr(8'h14, 32'h4);
    irq_is(0);
    settle(REC);
    chk("heat_msg", 0, hmsg);
    @(posedge mclk);
    pa <= 1'b1;
    host.rd(8'h40);
    #1 chk("unmapped", 0, rdata);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    settle(8);
    chk("status_n", 1, stat_n);
    chk("clamp", 0, clamp);
    chk("irq", 0, irq);
    t_overload();
    t_retry();
    t_gain();
    t_heat();
    test_done();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end
endmodule // test_overload_heatsink_overheat_supervisor
`default_nettype wire
